// file: verilog/uwl_defines.vh
// constants for the upstream window and lookup register slice
`ifndef UWL_DEFINES_VH
`define UWL_DEFINES_VH

// register byte offsets
`define UWL_OFS_SETUP 8'h34
`define UWL_OFS_UPPER 8'h38
`define UWL_OFS_PTR 8'h50
`define UWL_OFS_DATA 8'h54
`define UWL_OFS_REQ 8'h58
`define UWL_OFS_MASK 8'h60
`define UWL_OFS_CTRL 8'h80
`define UWL_OFS_STAT 8'h84
`define UWL_TBL_BASE 9'h100

// setup register fields
`define UWL_SETUP_TYPE 0
`define UWL_SETUP_AT_LO 1
`define UWL_SETUP_AT_HI 2
`define UWL_SETUP_PF 3
`define UWL_SETUP_SZ_LO 12
`define UWL_SETUP_RST 32'h0000_0002

// upper setup register fields
`define UWL_UPPER_EN 31
`define UWL_UPPER_RST 32'h0000_0000

// lookup entry fields
`define UWL_ENT_VALID 0
`define UWL_ENT_PF 3
`define UWL_ENT_MID_LO 8
`define UWL_ENT_MID_HI 24
`define UWL_ENT_TOP_LO 25
`define UWL_ENT_RST 32'h0000_0000
`define UWL_ENT_KEEP_256 32'hFFFF_FF09
`define UWL_ENT_KEEP_32M 32'hFE00_0009

// pointer, request and mask resets
`define UWL_PTR_RST 8'h00
`define UWL_REQ_RST 32'h0000_0000
`define UWL_MASK_RST 32'hFFFF_FFFF

// control register fields
`define UWL_CTRL_PG32M 0
`define UWL_CTRL_REVERSE 1
`define UWL_CTRL_MSI 2
`define UWL_CTRL_RST 3'h0

`endif

// file: verilog/uwl_regs.v
// upstream window 3 setup, lookup table access and page boundary requests
`timescale 1ns/1ns
`include "uwl_defines.vh"

// Functional notes
// RL1: setup type selector always reads zero
// RL2: address type 00=32-bit, 01=64-bit, reset 01
// RL3: setup size bits 31:12 shape window, reset 0
// RL4: upper size bits 30:0 shape upper base
// RL5: upper bit 31 enables 64-bit base
// RL6: eight-bit table pointer, upper bits read zero
// RL7: table touched only on data register access; code also reaches entries through the window at 100h
// RL8: software programs pointer before data access
// RL9: data write stores into pointed entry
// RL10: data read returns pointed entry
// RL11: entry bit 3 marks prefetchable page
// RL12: entry bits 24:8 writable at 256B pages
// RL13: entry bits 24:8 reserved at 32MB pages
// RL14: entry bits 31:25 base; table at 100h
// RL15: request bit n is page n
// RL16: last dword transfer sets page request bit
// RL17: unmasked set request raises secondary interrupt
// RL18: forward mode uses INTA_L or MSI
// RL19: reverse mode uses INTA message or MSI
// RL20: write one clears request bit
// RL21: mask blocks interrupt; masks reset all ones
// RL22: entry bit 0 valid; invalid never translates
// RL23: reserved bits read zero, ignore writes
module uwl_regs (
  // clock and reset
  input wire clock,
  input wire rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [8:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // page boundary events from the transfer engine
  input wire page_done,
  input wire [4:0] page_done_index,
  // translation lookup
  input wire xlat_req,
  input wire [5:0] xlat_page,
  output reg xlat_hit,
  output reg xlat_prefetch,
  output reg [31:0] xlat_base,
  // window 3 configuration
  output reg [19:0] win3_size_mask,
  output reg win3_prefetch,
  output reg win3_is64,
  output reg [30:0] win3_upper_mask,
  output reg win3_upper_en,
  // secondary interrupt signalling
  output reg sec_inta_n,
  output reg sec_inta_assert_msg,
  output reg sec_inta_deassert_msg,
  output reg sec_msi_req
);

  // merge write data by byte lanes
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] sel;
    integer k;
    begin
      lane_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          lane_merge[8*k +: 8] = new_val[8*k +: 8];
        end
      end
    end
  endfunction

  // the bits an entry may hold in the current page mode
  function [31:0] entry_keep;
    input pg32m;
    begin
      if (pg32m) begin
        entry_keep = `UWL_ENT_KEEP_32M; // see RL13
      end else begin
        entry_keep = `UWL_ENT_KEEP_256; // see RL12
      end
    end
  endfunction

  // register decode, shared by the write strobes and the data window
  function is_ofs;
    input [8:0] adr;
    input [7:0] ofs;
    begin
      is_ofs = (adr == {1'b0, ofs});
    end
  endfunction

  reg [31:0] setup;
  reg [31:0] upper;
  reg [7:0] ptr;
  reg [31:0] req;
  reg [31:0] mask;
  reg [2:0] ctrl;
  reg [31:0] tbl [0:63];
  reg irq_level;
  reg [31:0] rd_val;
  reg [31:0] next_req;
  reg [31:0] req_clr;
  reg [31:0] req_set;
  reg [5:0] tbl_idx;
  reg tbl_hit_bus;
  wire bus_req;
  wire bus_wr;
  wire [31:0] keep;
  wire next_irq;
  wire [31:0] ent_now;
  integer i;
  wire wr_setup;
  wire wr_upper;
  wire wr_ptr;
  wire wr_ctrl;
  wire wr_mask;
  wire wr_req;
  wire wr_tbl;
  wire irq_rise;
  wire irq_fall;
  wire use_pin;
  wire use_msg;
  wire use_msi;

  // one wait state: ack a cycle after the strobe, then drop it
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign keep = entry_keep(ctrl[`UWL_CTRL_PG32M]);
  assign ent_now = tbl[tbl_idx];

  // one strobe per register keeps the write processes short
  assign wr_setup = bus_wr & is_ofs(wb_adr_i, `UWL_OFS_SETUP);
  assign wr_upper = bus_wr & is_ofs(wb_adr_i, `UWL_OFS_UPPER);
  assign wr_ptr = bus_wr & is_ofs(wb_adr_i, `UWL_OFS_PTR) & wb_sel_i[0];
  assign wr_ctrl = bus_wr & is_ofs(wb_adr_i, `UWL_OFS_CTRL) & wb_sel_i[0];
  assign wr_mask = bus_wr & is_ofs(wb_adr_i, `UWL_OFS_MASK);
  assign wr_req = bus_wr & is_ofs(wb_adr_i, `UWL_OFS_REQ);
  assign wr_tbl = bus_wr & tbl_hit_bus; // see RL7
  assign irq_rise = next_irq & ~irq_level;
  assign irq_fall = ~next_irq & irq_level;
  // msi takes over from both wire and message signalling
  assign use_msi = ctrl[`UWL_CTRL_MSI];
  assign use_pin = ~ctrl[`UWL_CTRL_MSI] & ~ctrl[`UWL_CTRL_REVERSE]; // see RL18
  assign use_msg = ~ctrl[`UWL_CTRL_MSI] & ctrl[`UWL_CTRL_REVERSE]; // see RL19

  // table index comes from the held pointer or a direct window address
  always @* begin
    tbl_hit_bus = 1'b0;
    tbl_idx = ptr[7:2]; // see RL7
    if (wb_adr_i[8]) begin
      tbl_hit_bus = 1'b1;
      tbl_idx = wb_adr_i[7:2]; // see RL14
    end else if (is_ofs(wb_adr_i, `UWL_OFS_DATA)) begin
      tbl_hit_bus = 1'b1;
    end
  end

  // read multiplexer; unmapped offsets read zero
  always @* begin
    rd_val = 32'h0000_0000;
    if (tbl_hit_bus) begin
      rd_val = ent_now & keep; // see RL10
    end else begin
      case (wb_adr_i[7:0])
        `UWL_OFS_SETUP: begin
          rd_val = setup;
        end
        `UWL_OFS_UPPER: begin
          rd_val = upper;
        end
        `UWL_OFS_PTR: begin
          rd_val = {24'h00_0000, ptr}; // see RL6
        end
        `UWL_OFS_REQ: begin
          rd_val = req;
        end
        `UWL_OFS_MASK: begin
          rd_val = mask;
        end
        `UWL_OFS_CTRL: begin
          rd_val = {29'h0000_0000, ctrl};
        end
        `UWL_OFS_STAT: begin
          rd_val = {31'h0000_0000, irq_level};
        end
        default: begin
          rd_val = 32'h0000_0000;
        end
      endcase
    end
  end

  // wishbone answer; data is zero outside the ack cycle so no stale word lingers
  always @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_val;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // window 3 setup registers
  always @(posedge clock) begin
    if (rst) begin
      setup <= `UWL_SETUP_RST; // see RL2
      upper <= `UWL_UPPER_RST; // see RL5
    end else if (bus_wr) begin
      if (wr_setup) begin
        setup <= lane_merge(setup, wb_dat_i, wb_sel_i) & 32'hFFFF_F00A; // see RL1, see RL23
      end
      if (wr_upper) begin
        upper <= lane_merge(upper, wb_dat_i, wb_sel_i); // see RL4
      end
    end
  end

  // pointer and control; pointer bits 1:0 are held but never index the table
  always @(posedge clock) begin
    if (rst) begin
      ptr <= `UWL_PTR_RST;
      ctrl <= `UWL_CTRL_RST;
      mask <= `UWL_MASK_RST; // see RL21
    end else if (bus_wr) begin
      if (wr_ptr) begin
        ptr <= wb_dat_i[7:0]; // see RL6
      end
      if (wr_ctrl) begin
        ctrl <= wb_dat_i[2:0];
      end
      if (wr_mask) begin
        mask <= lane_merge(mask, wb_dat_i, wb_sel_i);
      end
    end
  end

  // lookup table; only a data register or 100h window access touches an entry
  always @(posedge clock) begin
    if (rst) begin
      for (i = 0; i < 64; i = i + 1) begin
        tbl[i] <= `UWL_ENT_RST; // see RL11
      end
    end else if (wr_tbl) begin
      // hidden bits stay stored, so a return to small pages still sees them
      tbl[tbl_idx] <= (lane_merge(ent_now, wb_dat_i, wb_sel_i) & keep) | (ent_now & ~keep); // see RL9, see RL13
    end
  end

  // request bits: a new event beats a clear in the same cycle
  always @* begin
    req_clr = 32'h0000_0000;
    req_set = 32'h0000_0000;
    if (wr_req) begin
      req_clr = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i); // see RL20
    end
    if (page_done) begin
      req_set[page_done_index] = 1'b1; // see RL15, see RL16
    end
    next_req = (req & ~req_clr) | req_set;
  end

  always @(posedge clock) begin
    if (rst) begin
      req <= `UWL_REQ_RST;
    end else begin
      req <= next_req;
    end
  end

  // interrupt follows the settled request and mask
  assign next_irq = |(req & ~mask); // see RL17, see RL21

  always @(posedge clock) begin
    if (rst) begin
      irq_level <= 1'b0;
    end else begin
      irq_level <= next_irq;
    end
  end

  // msi is an edge event whichever direction the bridge runs
  always @(posedge clock) begin
    if (rst) begin
      sec_msi_req <= 1'b0;
    end else begin
      sec_msi_req <= use_msi & irq_rise; // see RL18, see RL19
    end
  end

  // forward bridge drives the wire as a level
  always @(posedge clock) begin
    if (rst) begin
      sec_inta_n <= 1'b1;
    end else begin
      sec_inta_n <= ~(next_irq & use_pin); // see RL18
    end
  end

  // reverse bridge sends edge messages instead of a level
  always @(posedge clock) begin
    if (rst) begin
      sec_inta_assert_msg <= 1'b0;
    end else begin
      sec_inta_assert_msg <= use_msg & irq_rise; // see RL19
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      sec_inta_deassert_msg <= 1'b0;
    end else begin
      sec_inta_deassert_msg <= use_msg & irq_fall; // see RL19
    end
  end

  // translation lookup, one cycle; invalid entries never hit
  always @(posedge clock) begin
    if (rst) begin
      xlat_hit <= 1'b0;
    end else begin
      xlat_hit <= xlat_req & tbl[xlat_page][`UWL_ENT_VALID]; // see RL22
    end
  end

  // page attributes follow the index every cycle; only the hit is qualified
  always @(posedge clock) begin
    if (rst) begin
      xlat_prefetch <= 1'b0;
      xlat_base <= 32'h0000_0000;
    end else begin
      xlat_prefetch <= tbl[xlat_page][`UWL_ENT_PF]; // see RL11
      xlat_base <= tbl[xlat_page] & keep & 32'hFFFF_FF00; // see RL14
    end
  end

  // window configuration outputs mirror the setup registers
  always @(posedge clock) begin
    if (rst) begin
      win3_size_mask <= 20'h0_0000; // see RL3
      win3_prefetch <= 1'b0;
      win3_is64 <= 1'b1;
    end else begin
      win3_size_mask <= setup[31:`UWL_SETUP_SZ_LO]; // see RL3
      win3_prefetch <= setup[`UWL_SETUP_PF];
      win3_is64 <= setup[`UWL_SETUP_AT_LO]; // see RL2
    end
  end

  // upper half mirrors, one cycle behind the register like the rest
  always @(posedge clock) begin
    if (rst) begin
      win3_upper_mask <= 31'h0000_0000;
      win3_upper_en <= 1'b0;
    end else begin
      win3_upper_mask <= upper[30:0]; // see RL4
      win3_upper_en <= upper[`UWL_UPPER_EN]; // see RL5
    end
  end

endmodule // uwl_regs

// file: verif/uwl_regs_assertions.sv
// checker for the upstream window register slice
`timescale 1ns/1ns
module uwl_regs_assertions (
  // clock and reset
  input wire clock,
  input wire rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [8:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // configuration and interrupt outputs
  input wire win3_is64,
  input wire sec_inta_n,
  input wire sec_inta_assert_msg,
  input wire sec_msi_req
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // master holds we through ack, so it qualifies the read data
  wire rd = wb_ack_o && !wb_we_i;
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  chk_setup_ro: assert property (rd && wb_adr_i == 9'h034 |-> !wb_dat_o[0] && wb_dat_o[11:4] == 8'h0)
    else $error("setup fixed bits");
  chk_ptr_upper: assert property (rd && wb_adr_i == 9'h050 |-> wb_dat_o[31:8] == 24'h0) else $error("ptr upper");
  chk_entry_rsv: assert property (rd && (wb_adr_i == 9'h054 || wb_adr_i[8]) |-> wb_dat_o[2:1] == 2'h0
    && wb_dat_o[7:4] == 4'h0) else $error("entry reserved");
  chk_is64_reset: assert property ($fell(rst) |-> win3_is64) else $error("address type reset");
  chk_msi_only: assert property (sec_msi_req |-> sec_inta_n && !sec_inta_assert_msg) else $error("msi mix");
  chk_msg_rev: assert property (sec_inta_assert_msg |-> sec_inta_n) else $error("message with pin");
endmodule // uwl_regs_assertions

bind uwl_regs uwl_regs_assertions chk_i (.*);

// file: verif/uwl_far_model.sv
// transfer engine side: page boundary events and lookups
`timescale 1ns/1ns
module uwl_far_model (
  // clock
  input wire clock,
  // events and lookups
  output reg page_done,
  output reg [4:0] page_done_index,
  output reg xlat_req,
  output reg [5:0] xlat_page
);
  initial begin
    page_done = 1'b0;
    page_done_index = 5'h0;
    xlat_req = 1'b0;
    xlat_page = 6'h0;
  end
  task hit(input [4:0] n);
    @(posedge clock);
    page_done <= 1'b1;
    page_done_index <= n;
    @(posedge clock);
    page_done <= 1'b0;
    // stale index must not be counted
    page_done_index <= ~n;
  endtask
  task look(input [5:0] n);
    @(posedge clock);
    xlat_req <= 1'b1;
    xlat_page <= n;
    @(posedge clock);
    xlat_req <= 1'b0;
    xlat_page <= ~n;
  endtask
endmodule // uwl_far_model

// file: verif/tb.sv
// self-checking bench for the register slice
`timescale 1ns/1ns
module tb;
  reg clock, rst, cyc, stb, we;
  reg [8:0] adr;
  reg [3:0] sel;
  reg [31:0] wdat, rd, r;
  wire [31:0] dat;
  wire ack, pd, xr, hit, pf, uen, inta_n, am, msi, wpf, w64, dm;
  wire [31:0] base;
  wire [19:0] szm;
  wire [30:0] um;
  wire [4:0] pdi;
  wire [5:0] xp;
  integer failures, n_compared, n_am, n_msi, n_dm, i, k;
  uwl_regs uwl_regs_i (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .page_done(pd), .page_done_index(pdi),
    .xlat_req(xr), .xlat_page(xp), .xlat_hit(hit), .xlat_prefetch(pf), .xlat_base(base), .win3_size_mask(szm),
    .win3_prefetch(wpf), .win3_is64(w64), .win3_upper_mask(um), .win3_upper_en(uen), .sec_inta_n(inta_n),
    .sec_inta_assert_msg(am), .sec_inta_deassert_msg(dm), .sec_msi_req(msi));
  uwl_far_model uwl_far_model_i (.clock(clock), .page_done(pd), .page_done_index(pdi), .xlat_req(xr),
    .xlat_page(xp));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    n_am <= n_am + am;
    n_msi <= n_msi + msi;
    n_dm <= n_dm + dm;
  end
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  function [31:0] want(input [31:0] v, input big);
    want = v & (big ? 32'hFE000009 : 32'hFFFFFF09);
  endfunction
  task summarize;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ack is sampled before the slave's own update lands at the edge
  task bus(input w, input [8:0] a, input [31:0] d);
    integer n;
    @(posedge clock);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
    for (n = 0; n < 20 && ack !== 1'b1; n = n + 1) @(posedge clock);
    rd = dat;
    {cyc, stb, we} <= 3'h0;
    if (n == 20) begin
      failures = failures + 1;
      summarize;
    end
  endtask
  task rdchk(input [8:0] a, input [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  initial begin
    {rst, cyc, stb, we, adr, sel, wdat} = {4'h8, 9'h0, 4'h0, 32'h0};
    {failures, n_compared, n_am, n_msi, n_dm} = {5{32'h0}};
    r = 32'h28B8968B;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rdchk(9'h034, 32'h00000002);
    rdchk(9'h038, 32'h0);
    rdchk(9'h050, 32'h0);
    rdchk(9'h058, 32'h0);
    rdchk(9'h060, 32'hFFFFFFFF);
    rdchk(9'h040, 32'h0);
    $display("reset values done");
    for (i = 0; i < 4; i = i + 1) begin
      r = i ? xs(r) : 32'hFFFFFFFF;
      bus(1'b1, 9'h034, r);
      rdchk(9'h034, r & 32'hFFFFF00A);
      check({12'h0, szm}, {12'h0, r[31:12]});
      check({30'h0, w64, wpf}, {30'h0, r[1], r[3]});
      bus(1'b1, 9'h038, r);
      rdchk(9'h038, r);
      check({31'h0, uen}, {31'h0, r[31]});
      check({1'b0, um}, {1'b0, r[30:0]});
      bus(1'b1, 9'h050, {24'h0, r[13:8], 2'h0});
      bus(1'b1, 9'h054, r);
      rdchk(9'h054, want(r, 1'b0));
      rdchk({1'b1, r[13:8], 2'h0}, want(r, 1'b0));
      uwl_far_model_i.look(r[13:8]);
      @(negedge clock);
      check({30'h0, hit, pf}, {30'h0, r[0], r[3]});
      check(base, want(r, 1'b0) & 32'hFFFFFF00);
      bus(1'b1, 9'h080, 32'h1);
      rdchk(9'h054, want(r, 1'b1));
      bus(1'b1, 9'h054, ~r);
      bus(1'b1, 9'h080, 32'h0);
      rdchk(9'h054, want(~r, 1'b1) | (want(r, 1'b0) & 32'h01FFFF00));
    end
    $display("window and table done");
    k = r[4:0];
    bus(1'b1, 9'h060, ~(32'h1 << k));
    uwl_far_model_i.hit(k[4:0]);
    uwl_far_model_i.hit(k[4:0] ^ 5'h1);
    repeat (3) @(posedge clock);
    check({31'h0, inta_n}, 32'h0);
    rdchk(9'h058, (32'h1 << k) | (32'h1 << (k ^ 1)));
    bus(1'b1, 9'h058, 32'h1 << k);
    rdchk(9'h058, 32'h1 << (k ^ 1));
    check({31'h0, inta_n}, 32'h1);
    bus(1'b1, 9'h080, 32'h2);
    bus(1'b1, 9'h060, 32'h0);
    rdchk(9'h060, 32'h0);
    check(n_am, 32'h1);
    check({31'h0, inta_n}, 32'h1);
    bus(1'b1, 9'h058, 32'hFFFFFFFF);
    bus(1'b1, 9'h080, 32'h4);
    uwl_far_model_i.hit(k[4:0]);
    repeat (3) @(posedge clock);
    check(n_msi, 32'h1);
    check(n_dm, 32'h1);
    $display("page requests done");
    summarize;
  end
endmodule // tb
